// ### common/ccrr_defines.svh
// register offsets, field positions, reset values and counts for the contactless config and checksum bank
`ifndef CCRR_DEFINES_SVH
`define CCRR_DEFINES_SVH
// printed offsets are register indices; byte address is four times the index
`define CCRR_IDX_TX_TIMING 8'h1c
`define CCRR_IDX_RX_PARITY 8'h1d
`define CCRR_IDX_RSVD_1E 8'h1e
`define CCRR_IDX_SERIAL_RATE 8'h1f
`define CCRR_IDX_RSVD_20 8'h20
`define CCRR_IDX_CSUM_HIGH 8'h21
`define CCRR_IDX_CSUM_LOW 8'h22
`define CCRR_IDX_RSVD_23 8'h23
`define CCRR_RST_TX_TIMING 8'h62
`define CCRR_RST_RX_PARITY 8'h00
`define CCRR_RST_RSVD_1E 8'h00
`define CCRR_RST_SERIAL_RATE 8'heb
`define CCRR_RST_RSVD_20 8'h00
`define CCRR_RST_CSUM_HIGH 8'hff
`define CCRR_RST_CSUM_LOW 8'hff
`define CCRR_RST_RSVD_23 8'h88
`define CCRR_WAIT_LSB 0
`define CCRR_WAIT_MSB 1
`define CCRR_PARITY_OFF_BIT 4
`define CCRR_EXP_LSB 5
`define CCRR_EXP_MSB 7
`define CCRR_MANT_LSB 0
`define CCRR_MANT_MSB 4
`define CCRR_WAIT_BASE_BITS 3'h7
// writable masks; other bits keep reset value
`define CCRR_WMASK_TX_TIMING 8'h03
`define CCRR_WMASK_RX_PARITY 8'h10
`define CCRR_AXI_OKAY 2'h0
`define CCRR_AXI_SLVERR 2'h2
`endif

// ### common/ccrr_pkg.sv
// types shared by the contactless config and checksum register bank
package ccrr_pkg;
   // settings that steer the contactless and serial logic
   typedef struct packed {
      logic [1:0] extra_response_wait;
      logic [3:0] response_wait_bits;
      logic parity_off;
      logic [2:0] serial_rate_exponent;
      logic [4:0] serial_rate_mantissa;
   } ccrr_cfg_s;
   // one write strobe with data and lane enables
   typedef struct packed {
      logic en;
      logic [7:0] idx;
      logic [31:0] data;
      logic [3:0] strb;
   } ccrr_wr_s;
   // slave states of the write channel
   typedef enum logic [1:0] {
      CCRR_W_IDLE = 2'b00,
      CCRR_W_RESP = 2'b01
   } ccrr_wstate_e;
endpackage : ccrr_pkg

// ### hw/ccrr_parity_path.sv
// parity insertion and checking path steered by the parity-off control
`timescale 1ns/100ps
module ccrr_parity_path (
   input wire logic mclk,
   input wire logic rstn,
   input wire logic clk_en,
   input wire logic parity_off,
   input wire logic [7:0] tx_byte,
   input wire logic [8:0] rx_frame,
   input wire logic rx_frame_valid,
   output logic [8:0] tx_frame,
   output logic tx_frame_bits9,
   output logic [8:0] rx_data,
   output logic rx_parity_err
);
   import ccrr_pkg::*;
   logic [8:0] next_rx_data; // data passed on, parity bit included when off
   logic next_rx_parity_err; // odd parity failure on the received frame
   logic odd_par; // parity bit that makes the frame odd
   // transmit side is combinational: frame shrinks to eight bits when parity is off
   always_comb begin
      odd_par = ~(^tx_byte);
      if (parity_off) begin
         tx_frame = {1'b0, tx_byte};
         tx_frame_bits9 = 1'b0;
      end else begin
         tx_frame = {odd_par, tx_byte};
         tx_frame_bits9 = 1'b1;
      end
   end
   // receive side next values
   always_comb begin
      next_rx_data = rx_data;
      next_rx_parity_err = rx_parity_err;
      if (rx_frame_valid) begin
         if (parity_off) begin
            next_rx_data = rx_frame;
            next_rx_parity_err = 1'b0;
         end else begin
            next_rx_data = {1'b0, rx_frame[7:0]};
            next_rx_parity_err = ~(^rx_frame);
         end
      end
   end
   // registers for receive results; data outputs come from flops
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         rx_data <= 9'h000;
         rx_parity_err <= 1'b0;
      end else if (clk_en) begin
         rx_data <= next_rx_data;
         rx_parity_err <= next_rx_parity_err;
      end
   end
endmodule : ccrr_parity_path

// ### hw/ccrr_regs.sv
// contactless config and checksum result register bank with axi4-lite slave
//
// Function
// - two-bit extra wait, seven bits always added
// - parity-off stops parity generation and checking
// - with parity off, parity position is data
// - three-bit serial rate exponent at 1fh
// - five-bit serial rate mantissa at 1fh
// - checksum high byte read-only, reset ffh
// - checksum low byte read-only at 22h
// - reserved 1eh, 20h, 23h keep reset contents
//
// The AXI4-Lite register port is this design's own decision.
`timescale 1ns/100ps
`include "ccrr_defines.svh"
module ccrr_regs (
   input wire logic mclk,
   input wire logic rstn,
   input wire logic clk_en,
   // axi4-lite slave
   input wire logic [9:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [9:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // checksum engine result
   input wire logic [15:0] checksum_value,
   input wire logic checksum_load,
   // contactless framing path
   input wire logic [7:0] tx_byte,
   input wire logic [8:0] rx_frame,
   input wire logic rx_frame_valid,
   output logic [8:0] tx_frame,
   output logic tx_frame_bits9,
   output logic [8:0] rx_data,
   output logic rx_parity_err,
   // settings to the rest of the chip
   output ccrr_pkg::ccrr_cfg_s cfg
);
   import ccrr_pkg::*;

   // stored registers, full bytes; reserved bits hold their reset value
   logic [7:0] contactless_tx_timing;
   logic [7:0] contactless_rx_parity_ctrl;
   logic [7:0] host_serial_rate;
   logic [7:0] checksum_result_high;
   logic [7:0] checksum_result_low;
   logic [7:0] next_contactless_tx_timing;
   logic [7:0] next_contactless_rx_parity_ctrl;
   logic [7:0] next_host_serial_rate;
   logic [7:0] next_checksum_result_high;
   logic [7:0] next_checksum_result_low;

   // write channel capture: address and data may arrive in either order
   logic aw_held; // write address latched
   logic w_held; // write data latched
   logic [7:0] aw_idx;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   logic next_aw_held;
   logic next_w_held;
   logic [7:0] next_aw_idx;
   logic [31:0] next_w_data;
   logic [3:0] next_w_strb;
   ccrr_wstate_e wstate;
   ccrr_wstate_e next_wstate;
   logic [1:0] next_bresp;
   ccrr_wr_s wr; // write strobe into the register file
   logic wr_hit; // address decodes to a register of this bank

   // read channel
   logic next_rvalid;
   logic [31:0] next_rdata;
   logic [1:0] next_rresp;
   logic [7:0] ar_idx;
   logic [7:0] rd_byte;
   logic rd_hit;

   // one-deep channels: ready only while nothing is held for that channel
   assign s_axi_awready = ~aw_held && (wstate == CCRR_W_IDLE);
   assign s_axi_wready = ~w_held && (wstate == CCRR_W_IDLE);
   assign s_axi_arready = ~s_axi_rvalid;
   assign ar_idx = s_axi_araddr[9:2];

   // decode a register index; low byte lane carries the eight data bits
   function automatic logic idx_known(input logic [7:0] idx);
      idx_known = (idx >= `CCRR_IDX_TX_TIMING) && (idx <= `CCRR_IDX_RSVD_23);
   endfunction : idx_known

   // write channel next state
   always_comb begin
      next_aw_held = aw_held;
      next_w_held = w_held;
      next_aw_idx = aw_idx;
      next_w_data = w_data;
      next_w_strb = w_strb;
      next_wstate = wstate;
      next_bresp = s_axi_bresp;
      wr = '0;
      wr_hit = 1'b0;
      if (s_axi_awvalid && s_axi_awready) begin
         next_aw_held = 1'b1;
         next_aw_idx = s_axi_awaddr[9:2];
      end
      if (s_axi_wvalid && s_axi_wready) begin
         next_w_held = 1'b1;
         next_w_data = s_axi_wdata;
         next_w_strb = s_axi_wstrb;
      end
      unique case (wstate)
         CCRR_W_IDLE: begin
            // both halves present: commit the write and answer one cycle later
            if (aw_held && w_held) begin
               wr_hit = idx_known(aw_idx);
               wr.en = wr_hit;
               wr.idx = aw_idx;
               wr.data = w_data;
               wr.strb = w_strb;
               next_bresp = wr_hit ? `CCRR_AXI_OKAY : `CCRR_AXI_SLVERR;
               next_aw_held = 1'b0;
               next_w_held = 1'b0;
               next_wstate = CCRR_W_RESP;
            end
         end
         CCRR_W_RESP: begin
            if (s_axi_bready) begin
               next_wstate = CCRR_W_IDLE;
            end
         end
      endcase
   end

   // write channel registers
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_idx <= 8'h00;
         w_data <= 32'h0000_0000;
         w_strb <= 4'h0;
         wstate <= CCRR_W_IDLE;
         s_axi_bresp <= `CCRR_AXI_OKAY;
      end else if (clk_en) begin
         aw_held <= next_aw_held;
         w_held <= next_w_held;
         aw_idx <= next_aw_idx;
         w_data <= next_w_data;
         w_strb <= next_w_strb;
         wstate <= next_wstate;
         s_axi_bresp <= next_bresp;
      end
   end
   assign s_axi_bvalid = (wstate == CCRR_W_RESP);

   // register file next values; only writable fields take the bus data
   always_comb begin
      next_contactless_tx_timing = contactless_tx_timing;
      next_contactless_rx_parity_ctrl = contactless_rx_parity_ctrl;
      next_host_serial_rate = host_serial_rate;
      next_checksum_result_high = checksum_result_high;
      next_checksum_result_low = checksum_result_low;
      if (wr.en && wr.strb[0]) begin
         unique case (wr.idx)
            `CCRR_IDX_TX_TIMING: begin
               // only the wait field is stored; upper bits stay at reset value
               next_contactless_tx_timing = (`CCRR_RST_TX_TIMING & ~`CCRR_WMASK_TX_TIMING)
                  | (wr.data[7:0] & `CCRR_WMASK_TX_TIMING);
            end
            `CCRR_IDX_RX_PARITY: begin
               next_contactless_rx_parity_ctrl = (`CCRR_RST_RX_PARITY & ~`CCRR_WMASK_RX_PARITY)
                  | (wr.data[7:0] & `CCRR_WMASK_RX_PARITY);
            end
            `CCRR_IDX_SERIAL_RATE: begin
               next_host_serial_rate = wr.data[7:0];
            end
            default: begin
               // reserved and read-only locations drop the write
               next_host_serial_rate = host_serial_rate;
            end
         endcase
      end
      // checksum bytes change only from the engine, never from the bus
      if (checksum_load) begin
         next_checksum_result_high = checksum_value[15:8];
         next_checksum_result_low = checksum_value[7:0];
      end
   end

   // register file flops
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         contactless_tx_timing <= `CCRR_RST_TX_TIMING;
         contactless_rx_parity_ctrl <= `CCRR_RST_RX_PARITY;
         host_serial_rate <= `CCRR_RST_SERIAL_RATE;
         checksum_result_high <= `CCRR_RST_CSUM_HIGH;
         checksum_result_low <= `CCRR_RST_CSUM_LOW;
      end else if (clk_en) begin
         contactless_tx_timing <= next_contactless_tx_timing;
         contactless_rx_parity_ctrl <= next_contactless_rx_parity_ctrl;
         host_serial_rate <= next_host_serial_rate;
         checksum_result_high <= next_checksum_result_high;
         checksum_result_low <= next_checksum_result_low;
      end
   end

   // read mux; reserved locations return their fixed reset contents
   always_comb begin
      rd_hit = idx_known(ar_idx);
      unique case (ar_idx)
         `CCRR_IDX_TX_TIMING: rd_byte = contactless_tx_timing;
         `CCRR_IDX_RX_PARITY: rd_byte = contactless_rx_parity_ctrl;
         `CCRR_IDX_RSVD_1E: rd_byte = `CCRR_RST_RSVD_1E;
         `CCRR_IDX_SERIAL_RATE: rd_byte = host_serial_rate;
         `CCRR_IDX_RSVD_20: rd_byte = `CCRR_RST_RSVD_20;
         `CCRR_IDX_CSUM_HIGH: rd_byte = checksum_result_high;
         `CCRR_IDX_CSUM_LOW: rd_byte = checksum_result_low;
         `CCRR_IDX_RSVD_23: rd_byte = `CCRR_RST_RSVD_23;
         default: rd_byte = 8'h00;
      endcase
      // no validity gating: software checks the done flag elsewhere first
      next_rvalid = s_axi_rvalid;
      next_rdata = s_axi_rdata;
      next_rresp = s_axi_rresp;
      if (s_axi_rvalid && s_axi_rready) begin
         next_rvalid = 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
         next_rvalid = 1'b1;
         next_rdata = {24'h00_0000, rd_byte};
         next_rresp = rd_hit ? `CCRR_AXI_OKAY : `CCRR_AXI_SLVERR;
      end
   end

   // read channel flops
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= `CCRR_AXI_OKAY;
      end else if (clk_en) begin
         s_axi_rvalid <= next_rvalid;
         s_axi_rdata <= next_rdata;
         s_axi_rresp <= next_rresp;
      end
   end

   // settings out; the seven base bit periods are always added to the field
   always_comb begin
      cfg.extra_response_wait = contactless_tx_timing[`CCRR_WAIT_MSB:`CCRR_WAIT_LSB];
      cfg.response_wait_bits = {1'b0, `CCRR_WAIT_BASE_BITS}
         + {2'b00, contactless_tx_timing[`CCRR_WAIT_MSB:`CCRR_WAIT_LSB]};
      cfg.parity_off = contactless_rx_parity_ctrl[`CCRR_PARITY_OFF_BIT];
      cfg.serial_rate_exponent = host_serial_rate[`CCRR_EXP_MSB:`CCRR_EXP_LSB];
      cfg.serial_rate_mantissa = host_serial_rate[`CCRR_MANT_MSB:`CCRR_MANT_LSB];
   end

   // framing path obeys the parity-off setting
   ccrr_parity_path u_parity (
      .mclk(mclk),
      .rstn(rstn),
      .clk_en(clk_en),
      .parity_off(cfg.parity_off),
      .tx_byte(tx_byte),
      .rx_frame(rx_frame),
      .rx_frame_valid(rx_frame_valid),
      .tx_frame(tx_frame),
      .tx_frame_bits9(tx_frame_bits9),
      .rx_data(rx_data),
      .rx_parity_err(rx_parity_err)
   );
endmodule : ccrr_regs

// ### bench/ccrr_regs_assertions.sv
// port-level checker for the contactless config and checksum register bank
`timescale 1ns/100ps
`include "ccrr_defines.svh"
module ccrr_regs_assertions (
   input wire logic mclk,
   input wire logic rstn,
   input wire logic clk_en,
   input wire logic [9:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_bvalid,
   input wire logic [7:0] tx_byte,
   input wire logic [8:0] rx_frame,
   input wire logic rx_frame_valid,
   input wire logic [8:0] tx_frame,
   input wire logic tx_frame_bits9,
   input wire logic [8:0] rx_data,
   input wire logic rx_parity_err,
   input wire ccrr_pkg::ccrr_cfg_s cfg
);
   import ccrr_pkg::*;
   // single clock domain, so clocking and reset are stated once
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rstn);
   // a read request taken at this edge, and the index it asks for
   wire ar_take = s_axi_arvalid && s_axi_arready && clk_en;
   wire [7:0] rd_idx = s_axi_araddr[9:2];
   // a rx frame taken at this edge
   wire rx_take = rx_frame_valid && clk_en;

   a_wait_plus_seven: assert property (cfg.response_wait_bits == {2'h0, cfg.extra_response_wait} + 4'h7)
      else $error("response wait is not field plus seven");
   a_tx_parity_gen: assert property (tx_frame == (cfg.parity_off ? {1'b0, tx_byte} : {~^tx_byte, tx_byte}))
      else $error("tx frame parity bit wrong");
   a_rx_parity_chk: assert property (rx_take && !cfg.parity_off |=>
      rx_data == ($past(rx_frame) & 9'h0ff) && rx_parity_err == ~^$past(rx_frame))
      else $error("rx parity check wrong");
   a_rx_parity_off: assert property (rx_take && cfg.parity_off |=> rx_data == $past(rx_frame) && !rx_parity_err)
      else $error("rx frame not passed whole with parity off");
   // settings move only at the edge that commits a write, which is when bvalid rises
   a_cfg_on_write: assert property ($changed(cfg) |-> $rose(s_axi_bvalid))
      else $error("settings changed without a write");
   a_rsvd_contents: assert property (ar_take && (rd_idx == `CCRR_IDX_RSVD_1E || rd_idx == `CCRR_IDX_RSVD_20
      || rd_idx == `CCRR_IDX_RSVD_23) |=> s_axi_rdata == ($past(rd_idx) == `CCRR_IDX_RSVD_23 ? 32'h88 : 32'h0))
      else $error("reserved register content wrong");
   a_unmapped_err: assert property (ar_take && (rd_idx < 8'h1c || rd_idx > 8'h23) |=>
      s_axi_rresp == `CCRR_AXI_SLVERR && s_axi_rdata == 32'h0)
      else $error("unmapped read not refused");
   a_read_answer: assert property (ar_take |=> s_axi_rvalid && !s_axi_arready && s_axi_rdata[31:8] == 24'h0)
      else $error("read answer late or malformed");
   a_frame_length: assert property (tx_frame_bits9 == !cfg.parity_off)
      else $error("tx frame length flag wrong");
   // a low enable freezes every flop, so registered outputs keep their value across the edge
   a_freeze_hold: assert property (!clk_en |=> $stable(s_axi_rvalid) && $stable(s_axi_bvalid) && $stable(rx_data)
      && $stable(rx_parity_err) && $stable(cfg))
      else $error("state moved while enable low");
endmodule : ccrr_regs_assertions

// ### bench/tb.sv
// self-checking bench for the contactless config and checksum register bank
`timescale 1ns/100ps
module tb;
   import ccrr_pkg::*;
   // one row: index, value written, value read back, response expected
   typedef struct packed {
      logic [7:0] idx;
      logic [7:0] wval;
      logic [7:0] rval;
      logic [1:0] resp;
   } ccrr_row_s;
   logic mclk, rstn, clk_en, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, checksum_load, rx_frame_valid;
   logic tx_frame_bits9, rx_parity_err;
   logic [9:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, rd;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
   logic [15:0] checksum_value;
   logic [7:0] tx_byte;
   logic [8:0] rx_frame, tx_frame, rx_data;
   ccrr_cfg_s cfg;
   int error_cnt = 0;
   int tests_run = 0;
   // ordinary accesses; unmapped indices expect a refusal
   // last writes leave non-reset values so the mid-run reset has something to restore
   ccrr_row_s rows [14] = '{'{8'h1c, 8'hff, 8'h63, 2'h0}, '{8'h1c, 8'h00, 8'h60, 2'h0}, '{8'h1d, 8'h00, 8'h00, 2'h0},
      '{8'h1d, 8'hff, 8'h10, 2'h0}, '{8'h1e, 8'hff, 8'h00, 2'h0}, '{8'h1f, 8'heb, 8'heb, 2'h0},
      '{8'h1f, 8'h5a, 8'h5a, 2'h0}, '{8'h20, 8'hff, 8'h00, 2'h0}, '{8'h21, 8'h00, 8'hff, 2'h0},
      '{8'h22, 8'h00, 8'hff, 2'h0}, '{8'h23, 8'h00, 8'h88, 2'h0}, '{8'h1b, 8'h55, 8'h00, 2'h2},
      '{8'h24, 8'h55, 8'h00, 2'h2}, '{8'h00, 8'hff, 8'h00, 2'h2}};
   // reset contents of 1ch..23h in order
   logic [7:0] rst_vals [8] = '{8'h62, 8'h00, 8'h00, 8'heb, 8'h00, 8'hff, 8'hff, 8'h88};

   ccrr_regs u_dut (.*);

   // free-running 100 mhz clock
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end

   // count a comparison and report a mismatch
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         error_cnt++;
         $display("BAD %s exp %h got %h", name, exp, got);
      end
   endtask : chk

   // print the counts and the verdict, then stop
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : tally_and_finish

   // one write; each half drops at the edge that takes it, the answer is taken at the edge bvalid is seen
   task automatic axi_wr(input logic [7:0] idx, input logic [7:0] val, input logic [3:0] strb, output logic [1:0] resp);
      logic bd;
      bd = 1'b0;
      resp = 2'h3;
      s_axi_awaddr <= {idx, 2'b00};
      s_axi_wdata <= {24'h0, val};
      s_axi_wstrb <= strb;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      for (int n = 0; n < 40 && !bd; n++) begin
         @(posedge mclk);
         bd = s_axi_bvalid;
         resp = s_axi_bresp;
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      end
      if (!bd) begin
         error_cnt++;
         $display("BAD write_wait exp 1 got 0");
         tally_and_finish();
      end
   endtask : axi_wr

   // one read, same handshake discipline as the write
   task automatic axi_rd(input logic [7:0] idx, output logic [31:0] data, output logic [1:0] resp);
      logic rdn;
      rdn = 1'b0;
      s_axi_araddr <= {idx, 2'b00};
      s_axi_arvalid <= 1'b1;
      for (int n = 0; n < 40 && !rdn; n++) begin
         @(posedge mclk);
         rdn = s_axi_rvalid;
         data = s_axi_rdata;
         resp = s_axi_rresp;
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      end
      if (!rdn) begin
         error_cnt++;
         $display("BAD read_wait exp 1 got 0");
         tally_and_finish();
      end
   endtask : axi_rd

   // send one rx frame and one tx byte, then look at both paths
   task automatic rx_chk(input logic [8:0] frame, input logic [8:0] exp_data, input logic exp_err,
      input logic [8:0] exp_tx);
      rx_frame <= frame;
      rx_frame_valid <= 1'b1;
      tx_byte <= frame[7:0];
      @(posedge mclk);
      rx_frame_valid <= 1'b0;
      @(negedge mclk);
      chk("rx_data", exp_data, rx_data);
      chk("rx_parity_err", exp_err, rx_parity_err);
      chk("tx_frame", exp_tx, tx_frame);
      @(posedge mclk);
   endtask : rx_chk

   // main sequence
   initial begin
      {clk_en, s_axi_bready, s_axi_rready} = 3'b111;
      {rstn, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, checksum_load, rx_frame_valid} = 6'h0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb, checksum_value, tx_byte, rx_frame} = '0;
      repeat (6) @(posedge mclk);
      rstn <= 1'b1;
      @(posedge mclk);
      foreach (rows[i]) begin
         axi_wr(rows[i].idx, rows[i].wval, 4'h1, rsp);
         chk("bresp", rows[i].resp, rsp);
         axi_rd(rows[i].idx, rd, rsp);
         chk("rdata", rows[i].rval, rd);
         chk("rresp", rows[i].resp, rsp);
      end
      // second reset in mid-run, then every reset content
      rstn <= 1'b0;
      repeat (2) @(posedge mclk);
      rstn <= 1'b1;
      @(posedge mclk);
      for (int i = 0; i < 8; i++) begin
         axi_rd(8'h1c + 8'(i), rd, rsp);
         chk("reset_value", rst_vals[i], rd);
      end
      chk("wait_bits", 4'h9, cfg.response_wait_bits);
      axi_wr(8'h1c, 8'h03, 4'h1, rsp);
      chk("wait_bits", 4'ha, cfg.response_wait_bits);
      chk("wait_field", 2'h3, cfg.extra_response_wait);
      axi_wr(8'h1f, 8'h5a, 4'h1, rsp);
      chk("rate", 8'h5a, {cfg.serial_rate_exponent, cfg.serial_rate_mantissa});
      // a write with its byte lane off must leave the register alone
      axi_wr(8'h1f, 8'h00, 4'h0, rsp);
      axi_rd(8'h1f, rd, rsp);
      chk("lane_off", 8'h5a, rd);
      checksum_value <= 16'ha5c3;
      checksum_load <= 1'b1;
      @(posedge mclk);
      checksum_load <= 1'b0;
      axi_wr(8'h21, 8'h00, 4'h1, rsp);
      axi_rd(8'h21, rd, rsp);
      chk("csum_high", 8'ha5, rd);
      axi_rd(8'h22, rd, rsp);
      chk("csum_low", 8'hc3, rd);
      rx_chk(9'h003, 9'h003, 1'b1, 9'h103);
      rx_chk(9'h103, 9'h003, 1'b0, 9'h103);
      chk("frame_bits9", 1'b1, tx_frame_bits9);
      axi_wr(8'h1d, 8'h10, 4'h1, rsp);
      chk("parity_off", 1'b1, cfg.parity_off);
      chk("frame_bits9", 1'b0, tx_frame_bits9);
      rx_chk(9'h103, 9'h103, 1'b0, 9'h003);
      rx_chk(9'h003, 9'h003, 1'b0, 9'h003);
      // enable low: a checksum load and an rx frame must both be ignored
      clk_en <= 1'b0;
      checksum_value <= 16'h1234;
      {checksum_load, rx_frame_valid, rx_frame} <= {2'b11, 9'h0ff};
      repeat (2) @(posedge mclk);
      {clk_en, checksum_load, rx_frame_valid} <= 3'b100;
      chk("freeze_rx", 9'h003, rx_data);
      axi_rd(8'h21, rd, rsp);
      chk("freeze_csum", 8'ha5, rd);
      tally_and_finish();
   end
endmodule : tb

bind ccrr_regs ccrr_regs_assertions u_chk (.*);
